// ==== pcf_fetch_pipeline.sv ====
`timescale 1ns/1ps
module pcf_fetch_pipeline #(
    parameter logic [20:0] VEC_HIGH = 21'h000008,
    parameter logic [20:0] VEC_LOW = 21'h000018
)
(
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic RSTN_IN,
    // program memory
    output logic [20:0] PM_ADDR_OUT,
    output logic PM_RD_OUT,
    output logic PM_WR_OUT,
    output logic [7:0] PM_WDATA_OUT,
    input wire logic [15:0] PM_DATA_IN,
    // phase and execute view
    output logic [3:0] PHASE_OUT,
    output logic [15:0] EXEC_WORD_OUT,
    output logic EXEC_LIVE_OUT,
    output logic [11:0] OPERAND2_OUT,
    output logic OPND_RD_OUT,
    output logic DEST_WR_OUT,
    // datapath requests, sampled in phase four
    input wire logic SKIP_IN,
    input wire logic BRANCH_TAKEN_IN,
    input wire logic PCL_WR_IN,
    input wire logic [7:0] PCL_WDATA_IN,
    input wire logic PCL_RD_IN,
    input wire logic HLATCH_WR_IN,
    input wire logic ULATCH_WR_IN,
    input wire logic [7:0] LATCH_WDATA_IN,
    input wire logic TBL_RD_IN,
    input wire logic TBL_WR_IN,
    input wire logic [20:0] TBL_PTR_IN,
    input wire logic [7:0] TBL_WDATA_IN,
    // counter and latch view
    output logic [7:0] PC_LOW_OUT,
    output logic [7:0] PC_HIGH_LATCH_OUT,
    output logic [4:0] PC_UPPER_LATCH_OUT,
    output logic [7:0] TABLE_LATCH_OUT,
    // return address stack
    output logic STACK_PUSH_OUT,
    output logic STACK_POP_OUT,
    output logic [20:0] STACK_DATA_OUT,
    input wire logic [20:0] STACK_TOP_IN,
    // interrupt entry
    input wire logic INT_REQ_IN,
    input wire logic INT_HIGH_IN,
    output logic INT_ACK_OUT,
    // shadow save and restore
    input wire logic [7:0] STATUS_IN,
    input wire logic [7:0] WORK_IN,
    input wire logic [7:0] BANK_IN,
    output logic RESTORE_OUT,
    output logic [7:0] RESTORE_STATUS_OUT,
    output logic [7:0] RESTORE_WORK_OUT,
    output logic [7:0] RESTORE_BANK_OUT
);

////////////////////////////////////////////////////////////////////////////////
// helpers

    // absolute word address into byte address
    function automatic logic [20:0] word_target(input logic [19:0] w);
        word_target = {w, 1'b0};
    endfunction

    // relative word offset added to a byte base
    function automatic logic [20:0] rel_target(input logic [20:0] base,
                                               input logic [20:0] off);
        rel_target = base + {off[19:0], 1'b0};
    endfunction

////////////////////////////////////////////////////////////////////////////////
// phase generator

    logic [3:0] phase_w; // one-hot phase from the ring
    logic ph1;
    logic ph4;

    pcf_phase_gen #(.PHASE_N(pcf_pkg::PHASES)) u_phase (
        .clk_in(CLOCK_IN),
        .rstn_in(RSTN_IN),
        .phase_out(phase_w)
    );

    assign ph1 = |(phase_w & pcf_pkg::PH_ONE);
    assign ph4 = |(phase_w & pcf_pkg::PH_FOUR);

////////////////////////////////////////////////////////////////////////////////
// state

    logic [20:0] pc_reg; // byte address of next fetch
    logic [20:0] pc_next;
    logic [20:0] fetch_addr_reg; // address on the memory bus
    logic [15:0] ir_reg; // word executing this cycle
    logic ir_valid_reg; // cleared when the word was flushed
    logic live_reg; // valid and not a lone second word
    logic [7:0] hlatch_reg;
    logic [4:0] ulatch_reg;
    logic [7:0] tlatch_reg;
    logic tbl_pend_reg; // memory cycle belongs to the table
    logic tbl_wr_reg;
    logic [20:0] tbl_addr_reg;
    logic [7:0] tbl_wdata_reg;
    logic pm_rd_reg;
    logic pm_wr_reg;
    logic [11:0] opnd2_reg;
    logic opnd_rd_reg;
    logic dest_wr_reg;
    logic push_reg;
    logic pop_reg;
    logic [20:0] push_data_reg;
    logic ack_reg;
    // shadow copy, no port exposes it directly
    logic [7:0] sh_status_reg;
    logic [7:0] sh_work_reg;
    logic [7:0] sh_bank_reg;
    logic restore_reg;
    logic [7:0] rs_status_reg;
    logic [7:0] rs_work_reg;
    logic [7:0] rs_bank_reg;

////////////////////////////////////////////////////////////////////////////////
// decode of the executing word

    logic is_second; // top nibble all ones
    logic ex_live; // word really executes
    logic dp; // end of a live execute cycle
    logic dec_goto;
    logic dec_call;
    logic dec_bra;
    logic dec_relative_call;
    logic dec_bcond;
    logic dec_ret;
    logic dec_retint;
    logic dec_push;
    logic dec_twoword;
    logic fast_bit;
    logic abs_flow;
    logic rel_flow;
    logic pop_flow;
    logic flow_any;
    logic pcl_wr_ok;
    logic pcl_rd_ok;
    logic tbl_req;
    logic int_take;
    logic flush;
    logic shadow_save;
    logic shadow_load;
    logic [20:0] off_long;
    logic [20:0] off_short;
    logic [20:0] abs_addr;
    logic [20:0] rel_addr;
    logic [20:0] vec_addr;
    logic [7:0] tbl_byte;

    assign is_second = (ir_reg[15:12] == pcf_pkg::SECOND_TOP); // RQ19
    assign ex_live = ir_valid_reg && !is_second; // RQ19
    assign dp = ph4 && ex_live;
    assign dec_goto = dp && (ir_reg[15:8] == pcf_pkg::OP_GOTO);
    assign dec_call = dp && (ir_reg[15:9] == pcf_pkg::OP_CALL);
    assign dec_bra = dp && (ir_reg[15:11] == pcf_pkg::OP_BRA);
    assign dec_relative_call = dp && (ir_reg[15:11] == pcf_pkg::OP_RELATIVE_CALL);
    assign dec_bcond = dp && (ir_reg[15:11] == pcf_pkg::OP_BCOND) && BRANCH_TAKEN_IN;
    assign dec_ret = dp && (ir_reg[15:1] == pcf_pkg::OP_RETURN);
    assign dec_retint = dp && (ir_reg[15:1] == pcf_pkg::OP_RETINT);
    assign dec_push = dp && (ir_reg == pcf_pkg::OP_PUSH);
    // words whose partner carries 12 operand bits
    assign dec_twoword = dec_goto || dec_call || (dp && // RQ18
        ((ir_reg[15:12] == pcf_pkg::OP_FILE_MOVE) ||
         (ir_reg[15:8] == pcf_pkg::OP_LOAD_FSEL)));
    assign fast_bit = dec_call ? ir_reg[8] : ir_reg[0];
    assign abs_flow = dec_goto || dec_call;
    assign rel_flow = dec_bra || dec_relative_call || dec_bcond;
    assign pop_flow = dec_ret || dec_retint;
    assign flow_any = abs_flow || rel_flow || pop_flow;
    assign pcl_wr_ok = dp && PCL_WR_IN && !flow_any;
    assign pcl_rd_ok = dp && PCL_RD_IN;
    assign tbl_req = dp && (TBL_RD_IN || TBL_WR_IN) && !flow_any;
    // interrupts wait out flow changes, low byte writes and table cycles, but not a skip
    assign int_take = ph4 && INT_REQ_IN && !flow_any && !pcl_wr_ok && !tbl_req
        && !tbl_pend_reg;
    // prefetched word is discarded on any change of flow
    assign flush = flow_any || pcl_wr_ok || tbl_req || int_take || tbl_pend_reg // RQ14
        || (dp && SKIP_IN);
    assign shadow_save = int_take || (dec_call && fast_bit); // RQ1 RQ3 RQ4
    assign shadow_load = pop_flow && fast_bit; // RQ2 RQ4

////////////////////////////////////////////////////////////////////////////////
// targets

    // second word arrives on the bus in this same phase four
    assign abs_addr = word_target({PM_DATA_IN[11:0], ir_reg[7:0]}); // RQ16
    assign off_long = {{10{ir_reg[10]}}, ir_reg[10:0]};
    assign off_short = {{13{ir_reg[7]}}, ir_reg[7:0]};
    // base is the word after the branch
    assign rel_addr = dec_bcond ? rel_target(fetch_addr_reg, off_short) // RQ17
                                : rel_target(fetch_addr_reg, off_long); // RQ17
    assign vec_addr = INT_HIGH_IN ? VEC_HIGH : VEC_LOW;
    // even address holds the low byte
    assign tbl_byte = tbl_addr_reg[0] ? PM_DATA_IN[15:8] : PM_DATA_IN[7:0]; // RQ15 RQ21

    // priority: flow, low byte write, table, interrupt, then sequential
    assign pc_next =
        !ph4 ? ((ph1 && !tbl_pend_reg) ? pc_reg + pcf_pkg::PC_STEP : pc_reg) : // RQ7 RQ12
        abs_flow ? abs_addr : // RQ8
        rel_flow ? rel_addr : // RQ8
        pop_flow ? {STACK_TOP_IN[20:1], 1'b0} :
        pcl_wr_ok ? {ulatch_reg, hlatch_reg, PCL_WDATA_IN[7:1], 1'b0} : // RQ9 RQ20
        tbl_req ? fetch_addr_reg :
        int_take ? vec_addr : pc_reg;

////////////////////////////////////////////////////////////////////////////////
// counter, fetch address and instruction register

    // whole pipeline restarts at address zero
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            pc_reg <= pcf_pkg::PC_RESET; // RQ23
            fetch_addr_reg <= pcf_pkg::PC_RESET;
            ir_reg <= pcf_pkg::NOP_WORD; // RQ23
            ir_valid_reg <= 1'b0;
            live_reg <= 1'b0;
        end
        else
        begin
            pc_reg <= pc_next; // RQ6
            // phase one puts the fetch or table address on the bus
            if (ph1)
                fetch_addr_reg <= tbl_pend_reg ? tbl_addr_reg : pc_reg;
            // capture at phase four, executed in the next cycle
            if (ph4)
            begin
                ir_reg <= tbl_pend_reg ? pcf_pkg::NOP_WORD : PM_DATA_IN; // RQ12
                ir_valid_reg <= !flush; // RQ14
                live_reg <= !flush && (PM_DATA_IN[15:12] != pcf_pkg::SECOND_TOP);
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// latches and table access

    // an explicit latch write beats a copy from a low byte read
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            hlatch_reg <= pcf_pkg::BYTE_RESET; // RQ23
            ulatch_reg <= pcf_pkg::UPPER_RESET; // RQ23
            tlatch_reg <= pcf_pkg::BYTE_RESET;
        end
        else
        begin
            if (dp && HLATCH_WR_IN)
                hlatch_reg <= LATCH_WDATA_IN; // RQ6
            else if (pcl_rd_ok)
                hlatch_reg <= pc_reg[15:8]; // RQ10
            if (dp && ULATCH_WR_IN)
                ulatch_reg <= LATCH_WDATA_IN[4:0]; // RQ6
            else if (pcl_rd_ok)
                ulatch_reg <= pc_reg[20:16]; // RQ10
            if (ph4 && tbl_pend_reg && !tbl_wr_reg)
                tlatch_reg <= tbl_byte; // RQ21
        end
    end

    // table request borrows the next memory cycle
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            tbl_pend_reg <= 1'b0;
            tbl_wr_reg <= 1'b0;
            tbl_addr_reg <= pcf_pkg::PC_RESET;
            tbl_wdata_reg <= pcf_pkg::BYTE_RESET;
            pm_rd_reg <= 1'b0;
            pm_wr_reg <= 1'b0;
        end
        else
        begin
            if (ph4)
                tbl_pend_reg <= tbl_req;
            if (tbl_req)
            begin
                tbl_wr_reg <= TBL_WR_IN;
                tbl_addr_reg <= TBL_PTR_IN;
                tbl_wdata_reg <= TBL_WDATA_IN;
            end
            // read strobe spans phases two to four
            if (ph1)
                pm_rd_reg <= !(tbl_pend_reg && tbl_wr_reg);
            else if (ph4)
                pm_rd_reg <= 1'b0;
            // write strobe is phase two only, one byte
            pm_wr_reg <= ph1 && tbl_pend_reg && tbl_wr_reg; // RQ21
        end
    end

////////////////////////////////////////////////////////////////////////////////
// execute strobes, stack and shadow

    // data strobes only for words that really execute
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            opnd2_reg <= 12'h000;
            opnd_rd_reg <= 1'b0;
            dest_wr_reg <= 1'b0;
            push_reg <= 1'b0;
            pop_reg <= 1'b0;
            push_data_reg <= pcf_pkg::PC_RESET;
            ack_reg <= 1'b0;
        end
        else
        begin
            if (dec_twoword)
                opnd2_reg <= PM_DATA_IN[11:0]; // RQ18
            opnd_rd_reg <= |(phase_w & pcf_pkg::PH_ONE) && ex_live; // RQ13
            dest_wr_reg <= |(phase_w & pcf_pkg::PH_THREE) && ex_live; // RQ13
            push_reg <= dec_call || dec_relative_call || dec_push || int_take; // RQ22
            pop_reg <= pop_flow; // RQ22
            // call returns past its second word, others to the next word
            if (dec_call)
                push_data_reg <= pc_reg; // RQ22
            else if (dec_relative_call || dec_push || int_take)
                push_data_reg <= fetch_addr_reg; // RQ22
            ack_reg <= int_take;
        end
    end

    // single layer, both interrupt levels overwrite it
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            sh_status_reg <= pcf_pkg::BYTE_RESET;
            sh_work_reg <= pcf_pkg::BYTE_RESET;
            sh_bank_reg <= pcf_pkg::BYTE_RESET;
            restore_reg <= 1'b0;
            rs_status_reg <= pcf_pkg::BYTE_RESET;
            rs_work_reg <= pcf_pkg::BYTE_RESET;
            rs_bank_reg <= pcf_pkg::BYTE_RESET;
        end
        else
        begin
            if (shadow_save)
            begin
                sh_status_reg <= STATUS_IN; // RQ1 RQ3 RQ4
                sh_work_reg <= WORK_IN;
                sh_bank_reg <= BANK_IN;
            end
            restore_reg <= shadow_load; // RQ2
            // restore bus only changes on a fast return
            if (shadow_load)
            begin
                rs_status_reg <= sh_status_reg; // RQ2 RQ5
                rs_work_reg <= sh_work_reg;
                rs_bank_reg <= sh_bank_reg;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// outputs

    assign PM_ADDR_OUT = fetch_addr_reg;
    assign PM_RD_OUT = pm_rd_reg;
    assign PM_WR_OUT = pm_wr_reg;
    assign PM_WDATA_OUT = tbl_wdata_reg;
    assign PHASE_OUT = phase_w;
    assign EXEC_WORD_OUT = ir_reg;
    assign EXEC_LIVE_OUT = live_reg;
    assign OPERAND2_OUT = opnd2_reg;
    assign OPND_RD_OUT = opnd_rd_reg;
    assign DEST_WR_OUT = dest_wr_reg;
    assign PC_LOW_OUT = pc_reg[7:0]; // RQ6
    assign PC_HIGH_LATCH_OUT = hlatch_reg;
    assign PC_UPPER_LATCH_OUT = ulatch_reg;
    assign TABLE_LATCH_OUT = tlatch_reg;
    assign STACK_PUSH_OUT = push_reg;
    assign STACK_POP_OUT = pop_reg;
    assign STACK_DATA_OUT = push_data_reg;
    assign INT_ACK_OUT = ack_reg;
    assign RESTORE_OUT = restore_reg;
    assign RESTORE_STATUS_OUT = rs_status_reg;
    assign RESTORE_WORK_OUT = rs_work_reg;
    assign RESTORE_BANK_OUT = rs_bank_reg;

////////////////////////////////////////////////////////////////////////////////
// checks

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence s_data_strobes;
        OPND_RD_OUT ##2 DEST_WR_OUT;
    endsequence

    a_pc_even: assert property (pc_reg[0] == 1'b0) // RQ7
        else $error("counter bit zero set");
    a_seq_step: assert property ((ph1 && !tbl_pend_reg) |=> // RQ12
        pc_reg == $past(pc_reg) + pcf_pkg::PC_STEP)
        else $error("sequential step not two");
    a_flow_flush: assert property (flow_any |=> !ex_live [*4]) // RQ14
        else $error("prefetch not flushed");
    a_goto_load: assert property (dec_goto |=> // RQ16
        pc_reg == {$past(PM_DATA_IN[11:0]), $past(ir_reg[7:0]), 1'b0}
        && hlatch_reg == $past(hlatch_reg))
        else $error("absolute target wrong");
    a_rel_offset: assert property (dec_bra |=> // RQ17
        pc_reg == $past(fetch_addr_reg) + {$past(off_long[19:0]), 1'b0})
        else $error("branch offset not doubled");
    a_pcl_write: assert property (pcl_wr_ok |=> // RQ9
        pc_reg[20:8] == {ulatch_reg, hlatch_reg} && pc_reg[7:1] == $past(PCL_WDATA_IN[7:1]))
        else $error("latches not loaded");
    a_pcl_read: assert property ((pcl_rd_ok && !HLATCH_WR_IN && !ULATCH_WR_IN) |=> // RQ10
        {ulatch_reg, hlatch_reg} == $past(pc_reg[20:8]))
        else $error("latches not copied");
    a_shadow_save: assert property (int_take |=> // RQ1
        INT_ACK_OUT && STACK_PUSH_OUT && sh_work_reg == $past(WORK_IN)
        && pc_reg == $past(vec_addr))
        else $error("interrupt entry incomplete");
    a_fast_restore: assert property (shadow_load |=> // RQ2
        RESTORE_OUT && rs_status_reg == $past(sh_status_reg) && STACK_POP_OUT)
        else $error("fast return not restored");
    a_data_phases: assert property ((ph1 && ex_live) |=> s_data_strobes) // RQ13
        else $error("data strobes misplaced");
    a_lone_second: assert property ((ph1 && ir_valid_reg && is_second) |=> // RQ19
        !OPND_RD_OUT ##2 !DEST_WR_OUT)
        else $error("second word executed");
    a_table_byte: assert property ((ph4 && tbl_pend_reg && !tbl_wr_reg) |=> // RQ21
        tlatch_reg == ($past(tbl_addr_reg[0]) ? $past(PM_DATA_IN[15:8])
                                               : $past(PM_DATA_IN[7:0])))
        else $error("table byte wrong");

endmodule // pcf_fetch_pipeline

// ==== pcf_fetch_pipeline_tb.sv ====
`timescale 1ns/1ps
module pcf_fetch_pipeline_tb;
    // clock, reset and tallies
    logic CLOCK_IN = 1'b0;
    logic RSTN_IN = 1'b0;
    int n_fail = 0;
    int num_checks = 0;
    int n_push = 0, n_rest = 0, n_ack = 0;
    // design outputs
    logic [20:0] PM_ADDR_OUT, STACK_DATA_OUT;
    logic [15:0] PM_DATA_IN, EXEC_WORD_OUT;
    logic [11:0] OPERAND2_OUT;
    logic [7:0] PM_WDATA_OUT, PC_LOW_OUT, PC_HIGH_LATCH_OUT, TABLE_LATCH_OUT;
    logic [7:0] RESTORE_STATUS_OUT, RESTORE_WORK_OUT, RESTORE_BANK_OUT;
    logic [4:0] PC_UPPER_LATCH_OUT;
    logic [3:0] PHASE_OUT;
    logic PM_RD_OUT, PM_WR_OUT, EXEC_LIVE_OUT, OPND_RD_OUT, DEST_WR_OUT;
    logic STACK_PUSH_OUT, STACK_POP_OUT, INT_ACK_OUT, RESTORE_OUT;
    // requests, changed only at falling edges
    logic PCL_WR_IN = 1'b0, PCL_RD_IN = 1'b0, HLATCH_WR_IN = 1'b0, ULATCH_WR_IN = 1'b0;
    logic TBL_RD_IN = 1'b0, INT_REQ_IN = 1'b0, INT_HIGH_IN = 1'b0;
    logic [7:0] PCL_WDATA_IN = 8'h00, LATCH_WDATA_IN = 8'h00;
    logic [7:0] STATUS_IN = 8'hA1, WORK_IN = 8'hB2, BANK_IN = 8'hC3;
    logic [20:0] TBL_PTR_IN = 21'h000000, STACK_TOP_IN = 21'h00001C;
    ///////////////////////////////////////
    // skip, condition and table write paths are left idle
    pcf_fetch_pipeline DUT (.CLOCK_IN, .RSTN_IN, .PM_ADDR_OUT, .PM_RD_OUT, .PM_WR_OUT,
        .PM_WDATA_OUT, .PM_DATA_IN, .PHASE_OUT, .EXEC_WORD_OUT, .EXEC_LIVE_OUT,
        .OPERAND2_OUT, .OPND_RD_OUT, .DEST_WR_OUT, .SKIP_IN(1'b0), .BRANCH_TAKEN_IN(1'b0),
        .PCL_WR_IN, .PCL_WDATA_IN, .PCL_RD_IN, .HLATCH_WR_IN, .ULATCH_WR_IN,
        .LATCH_WDATA_IN, .TBL_RD_IN, .TBL_WR_IN(1'b0), .TBL_PTR_IN, .TBL_WDATA_IN(8'h00),
        .PC_LOW_OUT, .PC_HIGH_LATCH_OUT, .PC_UPPER_LATCH_OUT, .TABLE_LATCH_OUT,
        .STACK_PUSH_OUT, .STACK_POP_OUT, .STACK_DATA_OUT, .STACK_TOP_IN, .INT_REQ_IN,
        .INT_HIGH_IN, .INT_ACK_OUT, .STATUS_IN, .WORK_IN, .BANK_IN, .RESTORE_OUT,
        .RESTORE_STATUS_OUT, .RESTORE_WORK_OUT, .RESTORE_BANK_OUT);
    // program memory model
    pcf_prog_mem u_mem (.clk_in(CLOCK_IN), .addr_in(PM_ADDR_OUT), .rd_in(PM_RD_OUT),
        .data_out(PM_DATA_IN));
    ///////////////////////////////////////
    // 200 MHz clock
    always #2.5 CLOCK_IN = ~CLOCK_IN;
    // tally one-cycle pulses
    always @(posedge CLOCK_IN)
    begin
        if (STACK_PUSH_OUT === 1'b1)
            n_push++;
        if (RESTORE_OUT === 1'b1)
            n_rest++;
        if (INT_ACK_OUT === 1'b1)
            n_ack++;
    end
    ///////////////////////////////////////
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
        num_checks++;
        if (s !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask
    task automatic ld(input logic [8:0] a, input logic [15:0] w);
        u_mem.mem[a] = w[7:0];
        u_mem.mem[a + 9'h001] = w[15:8];
    endtask
    task automatic clr();
        {PCL_WR_IN, PCL_RD_IN, HLATCH_WR_IN, ULATCH_WR_IN, TBL_RD_IN, INT_REQ_IN} = 6'h00;
    endtask
    // run to phase two of the next cycle, checking the rotation
    task automatic nextc();
        logic [3:0] prev;
        int n;
        n = 0;
        prev = PHASE_OUT;
        do
        begin
            @(negedge CLOCK_IN);
            n++;
            chk("phase", 24'({prev[2:0], prev[3]}), 24'(PHASE_OUT));
            prev = PHASE_OUT;
        end
        while (PHASE_OUT !== pcf_pkg::PH_TWO && n < 8);
    endtask
    // one instruction cycle: fetch address and whether execute is live
    task automatic step(input logic [20:0] a, input logic lv);
        nextc();
        clr();
        chk("fetch address", 24'(a), 24'(PM_ADDR_OUT));
        chk("read strobe", 24'h1, 24'(PM_RD_OUT));
        chk("live", 24'(lv), 24'(EXEC_LIVE_OUT));
    endtask
    task automatic t_flow();
        step(21'h000000, 1'b0);
        step(21'h000002, 1'b1);
        chk("exec word", 24'h000E55, 24'(EXEC_WORD_OUT));
        step(21'h000004, 1'b1);
        step(21'h000010, 1'b0);
        step(21'h000012, 1'b1);
        step(21'h000018, 1'b0);
        $display("test flow done");
    endtask
    // fast call saves, fast return hands back the old values
    task automatic t_call();
        step(21'h00001A, 1'b1);
        step(21'h000030, 1'b0);
        chk("push data", 24'h00001C, 24'(STACK_DATA_OUT));
        chk("push count", 24'h1, 24'(n_push));
        {STATUS_IN, WORK_IN, BANK_IN} = 24'h112233;
        step(21'h000032, 1'b1);
        step(21'h00001C, 1'b0);
        chk("restore count", 24'h1, 24'(n_rest));
        chk("restored", 24'hA1B2C3, {RESTORE_STATUS_OUT, RESTORE_WORK_OUT, RESTORE_BANK_OUT});
        step(21'h00001E, 1'b1);
        step(21'h000020, 1'b0);
        $display("test call done");
    endtask
    // latches enter on a low-byte write, come back on a read
    task automatic t_pcl();
        step(21'h000022, 1'b1);
        {HLATCH_WR_IN, ULATCH_WR_IN, LATCH_WDATA_IN} = {2'b11, 8'h01};
        step(21'h000024, 1'b1);
        {PCL_WR_IN, PCL_WDATA_IN} = {1'b1, 8'h41};
        step(21'h010140, 1'b0);
        step(21'h010142, 1'b1);
        {HLATCH_WR_IN, LATCH_WDATA_IN} = {1'b1, 8'h7E};
        step(21'h010144, 1'b1);
        chk("high latch", 24'h00007E, 24'(PC_HIGH_LATCH_OUT));
        PCL_RD_IN = 1'b1;
        step(21'h010146, 1'b1);
        chk("latches", 24'h000101, 24'({PC_UPPER_LATCH_OUT, PC_HIGH_LATCH_OUT}));
        $display("test low byte done");
    endtask
    // interrupt entry overwrites the shadow, fast return restores it
    task automatic t_int();
        {STATUS_IN, WORK_IN, BANK_IN} = 24'h445566;
        {INT_REQ_IN, INT_HIGH_IN, STACK_TOP_IN} = {2'b11, 21'h010146};
        step(21'h000008, 1'b0);
        chk("ack count", 24'h1, 24'(n_ack));
        chk("push data", 24'h010146, 24'(STACK_DATA_OUT));
        {STATUS_IN, WORK_IN, BANK_IN} = 24'h778899;
        step(21'h00000A, 1'b1);
        step(21'h010146, 1'b0);
        chk("restored", 24'h445566, {RESTORE_STATUS_OUT, RESTORE_WORK_OUT, RESTORE_BANK_OUT});
        $display("test interrupt done");
    endtask
    // odd pointer picks the high byte of a word
    task automatic t_table();
        step(21'h010148, 1'b1);
        {TBL_RD_IN, TBL_PTR_IN} = {1'b1, 21'h000003};
        nextc();
        clr();
        chk("table address", 24'h000003, 24'(PM_ADDR_OUT));
        nextc();
        chk("table latch", 24'h0000EF, 24'(TABLE_LATCH_OUT));
        $display("test table done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ///////////////////////////////////////
    // program image, reset, then the tests in order
    initial
    begin
        for (int i = 0; i < 512; i++)
            u_mem.mem[i] = 8'h00;
        ld(9'h000, 16'h0E55);
        ld(9'h002, 16'hEF08);
        ld(9'h004, 16'hF000);
        ld(9'h008, 16'h0011);
        ld(9'h010, 16'hD003);
        ld(9'h018, 16'hED18);
        ld(9'h01A, 16'hF000);
        ld(9'h01C, 16'h0E02);
        ld(9'h01E, 16'hF123);
        ld(9'h030, 16'h0013);
        repeat (8) @(negedge CLOCK_IN);
        RSTN_IN = 1'b1;
        t_flow();
        t_call();
        t_pcl();
        t_int();
        t_table();
        test_done();
    end
    // about 25 instruction cycles are needed; allow several times that
    initial
    begin
        #3000;
        n_fail++;
        test_done();
    end
endmodule // pcf_fetch_pipeline_tb

// ==== pcf_phase_gen.sv ====
`timescale 1ns/1ps
module pcf_phase_gen #(
    parameter int PHASE_N = pcf_pkg::PHASES
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // one-hot phase, bit 0 is phase one
    output logic [PHASE_N-1:0] phase_out
);

////////////////////////////////////////////////////////////////////////////////

    // ring of flops, non-overlap is by construction
    logic [PHASE_N-1:0] phase_reg;
    logic [PHASE_N-1:0] phase_next;

    // rotate one place per input clock
    assign phase_next = {phase_reg[PHASE_N-2:0], phase_reg[PHASE_N-1]}; // RQ11

    // ring starts in phase one after reset
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            phase_reg <= {{(PHASE_N-1){1'b0}}, 1'b1};
        else
            phase_reg <= phase_next;
    end

    assign phase_out = phase_reg;

////////////////////////////////////////////////////////////////////////////////

    // one full pass through all phases
    sequence s_phase_pass;
        phase_reg[0] ##1 phase_reg[1] ##1 phase_reg[2] ##1 phase_reg[3];
    endsequence

    a_phase_onehot: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ11
        $onehot(phase_reg))
        else $error("phase ring not one-hot");

    a_phase_pass: assert property (@(posedge clk_in) disable iff (!rstn_in) // RQ11
        phase_reg[0] |-> s_phase_pass ##1 phase_reg[0])
        else $error("phase ring skipped a phase");

endmodule // pcf_phase_gen

// ==== pcf_pkg.sv ====
// Functional notes
// RQ1: interrupt entry saves status, working, bank
// RQ2: fast interrupt return reloads shadow copy
// RQ3: either priority entry overwrites the shadow
// RQ4: fast call saves, fast return restores
// RQ5: shadow copy has no software access path
// RQ6: 21-bit counter, upper bits via latches
// RQ7: counter bit zero stays zero, steps two
// RQ8: call, goto, branch bypass the latches
// RQ9: low byte write loads upper bits
// RQ10: low byte read copies upper bits out
// RQ11: clock divided into four phases
// RQ12: increment phase one, capture phase four
// RQ13: operand read phase two, write four
// RQ14: flow change flushes prefetched word
// RQ15: low byte at even address
// RQ16: absolute target fills counter bits 20:1
// RQ17: branch offsets count words, doubled
// RQ18: two-word second word carries 12 bits
// RQ19: lone second word executes as no-op
// RQ20: working add to low byte, even only
// RQ21: table access moves one byte
// RQ22: calls and interrupts push, returns pop
// RQ23: reset clears counter, latches, pipeline
package pcf_pkg;
    // counter geometry and reset values
    localparam int PC_W = 21;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [4:0] UPPER_RESET = 5'h00;
    // phase sequence, one-hot, four per instruction cycle
    localparam int PHASES = 4;
    localparam logic [3:0] PH_ONE = 4'h1;
    localparam logic [3:0] PH_TWO = 4'h2;
    localparam logic [3:0] PH_THREE = 4'h4;
    localparam logic [3:0] PH_FOUR = 4'h8;
    // instruction words
    localparam logic [15:0] NOP_WORD = 16'hF000;
    localparam logic [3:0] SECOND_TOP = 4'hF;
    localparam logic [7:0] OP_GOTO = 8'hEF;
    localparam logic [6:0] OP_CALL = 7'h76;
    localparam logic [7:0] OP_LOAD_FSEL = 8'hEE;
    localparam logic [3:0] OP_FILE_MOVE = 4'hC;
    localparam logic [4:0] OP_BRA = 5'h1A;
    localparam logic [4:0] OP_RELATIVE_CALL = 5'h1B;
    localparam logic [4:0] OP_BCOND = 5'h1C;
    localparam logic [14:0] OP_RETINT = 15'h0008;
    localparam logic [14:0] OP_RETURN = 15'h0009;
    localparam logic [15:0] OP_PUSH = 16'h0005;
endpackage

// ==== pcf_prog_mem.sv ====
`timescale 1ns/1ps
module pcf_prog_mem
(
    // bus side
    input wire logic clk_in,
    input wire logic [20:0] addr_in,
    input wire logic rd_in,
    output logic [15:0] data_out
);
    ///////////////////////////////////////
    logic [7:0] mem [0:511]; // byte image, loaded by the bench
    logic [15:0] last_reg; // word last put on the bus
    logic [15:0] word; // word at the even address
    // low byte even, high byte odd
    assign word = {mem[{addr_in[8:1], 1'b1}], mem[{addr_in[8:1], 1'b0}]};
    // idle bus shows the inverse, so a stale word never reads right
    assign data_out = rd_in ? word : ~last_reg;
    // remember what was driven
    always_ff @(posedge clk_in)
    begin
        if (rd_in)
            last_reg <= word;
    end
endmodule // pcf_prog_mem
